// >>> include/bsmc_map.svh
// constants of the boot strap and mode configuration block
`ifndef BSMC_MAP_SVH
`define BSMC_MAP_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define BSMC_CLK_MHZ        50
`define BSMC_RST_PROC_NS    1000
`define BSMC_RST_PROC_CYC   ((`BSMC_RST_PROC_NS * `BSMC_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------------
// apb register byte offsets
// ----------------------------------------------------------------------
`define BSMC_OFS_GPIO_CTRL  8'h00
`define BSMC_OFS_GPIO_IN    8'h04
`define BSMC_OFS_STRAPS     8'h08
`define BSMC_OFS_STATE      8'h0C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BSMC_CTRL_ALT_LSB   0
`define BSMC_CTRL_OUT_LSB   4
`define BSMC_CTRL_DIR_LSB   8
`define BSMC_ST_CLK_LSB     0
`define BSMC_ST_FREQ_BIT    3
`define BSMC_ST_SLOW_BIT    4
`define BSMC_ST_PAIR_LSB    5
`define BSMC_ST_MODE_LSB    11
`define BSMC_ST_HALT_BIT    15

// ----------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------
`define BSMC_CTRL_RST       12'h000
`define BSMC_REFCLK_LO_MHZ  8'h64
`define BSMC_REFCLK_HI_MHZ  8'h7D
`define BSMC_SMB_SLOW_KHZ   9'h064
`define BSMC_SMB_FAST_KHZ   9'h190
`define BSMC_MODE_EE        4'h1
`define BSMC_MODE_FIX_LO    4'h8
`define BSMC_MODE_FIX_HI    4'hB
`define BSMC_MODE_MULTI     4'hC
`define BSMC_MODE_MULTI_EE  4'hD

`endif

// >>> include/bsmc_pkg.sv
// types of the boot strap and mode configuration block
package bsmc_pkg;

  typedef enum logic [1:0] {
    BSMC_ST_CAPTURE,
    BSMC_ST_RESET_PROC,
    BSMC_ST_HALTED,
    BSMC_ST_RUN
  } bsmc_state_type;

  typedef enum logic [1:0] {
    BSMC_PM_SINGLE,
    BSMC_PM_SINGLE_FIXED_UP,
    BSMC_PM_MULTI,
    BSMC_PM_RESERVED
  } bsmc_part_type;

endpackage : bsmc_pkg

// >>> core/bsmc_strap_latch.sv
// strap capture register, loaded once at reset release
`timescale 1ns/1ps
`include "bsmc_map.svh"
module bsmc_strap_latch
  import bsmc_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic         i_clk,     // system clock
  input  wire logic         i_arst_n,  // async reset, active low
  input  wire logic [W-1:0] i_raw,     // live strap pins
  output logic      [W-1:0] o_val_q,   // captured straps
  output logic              o_valid_q  // straps captured
);

  logic [W-1:0] val_d;
  logic         valid_d;

  generate
    if (W < 1)
    begin : g_chk
      $error("bsmc_strap_latch: W must be at least 1");
    end
  endgenerate

  // only the first edge after release loads; later pin motion is ignored
  always_comb
  begin
    val_d   = o_val_q;
    valid_d = 1'b1;
    if (!o_valid_q)
    begin
      val_d = i_raw;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_val_q   <= '0;
      o_valid_q <= 1'b0;
    end
    else
    begin
      o_val_q   <= val_d;
      o_valid_q <= valid_d;
    end
  end

endmodule : bsmc_strap_latch

// >>> core/bsmc_mode_decode.sv
// partition mode and port pair merge decoder
`timescale 1ns/1ps
`include "bsmc_map.svh"
module bsmc_mode_decode
  import bsmc_pkg::*;
#(
  parameter int PAIRS = 6
)(
  input  wire logic             i_clk,        // system clock
  input  wire logic             i_arst_n,     // async reset, active low
  input  wire logic             i_valid,      // straps captured
  input  wire logic [3:0]       i_mode,       // captured partition mode
  input  wire logic [PAIRS-1:0] i_combine_n,  // captured merge straps
  output logic      [PAIRS-1:0] o_merged_q,   // even port absorbs odd
  output bsmc_part_type         o_kind_q,     // partition kind
  output logic                  o_eeprom_q,   // eeprom initialisation
  output logic                  o_up_p2_q,    // port 2 is upstream
  output logic                  o_p0_dis_q,   // port 0 disabled
  output logic                  o_p2_dis_q    // port 2 disabled
);

  logic [PAIRS-1:0] merged_d;
  bsmc_part_type    kind_d;
  logic             eeprom_d;
  logic             up_p2_d;

  generate
    if (PAIRS < 1)
    begin : g_chk
      $error("bsmc_mode_decode: PAIRS must be at least 1");
    end
    for (genvar g = 0; g < PAIRS; g++)
    begin : g_pair
      // low strap merges, high keeps two x4 ports
      assign merged_d[g] = i_valid & ~i_combine_n[g];
    end
  endgenerate

  always_comb
  begin
    kind_d   = BSMC_PM_RESERVED;
    eeprom_d = 1'b0;
    up_p2_d  = 1'b0;
    if (i_mode < `BSMC_MODE_FIX_LO)
    begin
      if (i_mode <= `BSMC_MODE_EE)
      begin
        kind_d   = BSMC_PM_SINGLE;
        eeprom_d = i_mode[0];
      end
    end
    else if (i_mode <= `BSMC_MODE_FIX_HI)
    begin
      kind_d   = BSMC_PM_SINGLE_FIXED_UP;
      up_p2_d  = i_mode[0];
      eeprom_d = i_mode[1];
    end
    else if (i_mode <= `BSMC_MODE_MULTI_EE)
    begin
      kind_d   = BSMC_PM_MULTI;
      eeprom_d = i_mode[0];
    end
    if (!i_valid)
    begin
      kind_d   = BSMC_PM_RESERVED;
      eeprom_d = 1'b0;
      up_p2_d  = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_merged_q <= '0;
      o_kind_q   <= BSMC_PM_RESERVED;
      o_eeprom_q <= 1'b0;
      o_up_p2_q  <= 1'b0;
      o_p0_dis_q <= 1'b0;
      o_p2_dis_q <= 1'b0;
    end
    else
    begin
      o_merged_q <= merged_d;
      o_kind_q   <= kind_d;
      o_eeprom_q <= eeprom_d;
      o_up_p2_q  <= up_p2_d;
      o_p0_dis_q <= (kind_d == BSMC_PM_SINGLE_FIXED_UP) & up_p2_d;
      o_p2_dis_q <= (kind_d == BSMC_PM_SINGLE_FIXED_UP) & ~up_p2_d;
    end
  end

  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  merge_map_a : assert property (
    i_valid |=> o_merged_q == ~$past(i_combine_n))
    else $error("merge flags do not follow the straps");

  fixed_up_a : assert property (
    (i_valid && i_mode == 4'hA) |=>
      o_kind_q == BSMC_PM_SINGLE_FIXED_UP && o_eeprom_q && !o_up_p2_q && o_p2_dis_q && !o_p0_dis_q)
    else $error("mode 0xA decoded wrongly");

  reserved_a : assert property (
    (i_valid && (i_mode inside {[4'h2:4'h7], 4'hE, 4'hF})) |=> o_kind_q == BSMC_PM_RESERVED)
    else $error("reserved mode not flagged");

  multi_ee_a : assert property (
    (i_valid && i_mode == 4'hD) |=> o_kind_q == BSMC_PM_MULTI && o_eeprom_q)
    else $error("mode 0xD decoded wrongly");

endmodule : bsmc_mode_decode

// >>> core/bsmc_top.sv
// boot strap capture, reset halt sequencer, apb registers and slot 4 pin mux
//----------------------------------------------------------------------
// Summary of operation
// - pins 50..53 are gpio or slot 4 attention, power led, power enable, reset_n
// - refclk strap 0 means 100 MHz, 1 means 125 MHz
// - slow strap forces host smbus to 100 kHz, else 400 kHz, no override
// - low merge strap: even port absorbs odd, odd lanes become 4..7 of x8
// - high merge strap keeps both ports as separate x4 ports
// - pairs 0/1 through 10/11 each follow their own merge strap
// - three-bit strap selects port clocking mode
// - global reset low resets every element of the block
// - hold strap during reset: run reset procedure, stay in reset, smbus active
// - halted state ends only when an smbus master clears the halt bit
// - mode 0 single partition, 1 adds eeprom init, 2..7 reserved
// - modes 8..B fix port 0 or 2 upstream, A and B add eeprom init
// - mode C multi partition, D adds eeprom init, E and F reserved
//----------------------------------------------------------------------
`timescale 1ns/1ps
`include "bsmc_map.svh"
module bsmc_top
  import bsmc_pkg::*;
#(
  parameter int RST_PROC_CYC = `BSMC_RST_PROC_CYC,
  parameter int PAIRS        = 6
)(
  input  wire logic             I_CLK_SYS,            // 50 MHz system clock
  input  wire logic             I_ARST_N,             // global reset, active low
  input  wire logic [2:0]       I_PORT_CLOCKING_SEL,  // clock mode strap
  input  wire logic             I_REFCLK_FREQ_SEL,    // refclk frequency strap
  input  wire logic             I_SLOW_SMBUS_STRAP,   // host smbus slow strap
  input  wire logic [PAIRS-1:0] I_PAIR_COMBINE_N,     // merge straps, bit0 = pair 0/1
  input  wire logic [3:0]       I_PARTITION_MODE,     // partition mode strap
  input  wire logic             I_HOLD_IN_RESET,      // reset halt strap
  input  wire logic             I_HALT_CLEAR,         // halt bit cleared by smbus
  input  wire logic             I_SLOT4_ATTN_LED,     // hot-plug attention led
  input  wire logic             I_SLOT4_POWER_LED,    // hot-plug power led
  input  wire logic             I_SLOT4_POWER_EN,     // hot-plug power enable
  input  wire logic             I_SLOT4_RESET_N,      // hot-plug slot reset
  input  wire logic [3:0]       I_GPIO_IN,            // pins 50..53 input level
  output logic      [3:0]       O_GPIO_OUT,           // pins 50..53 drive level
  output logic      [3:0]       O_GPIO_OE,            // pins 50..53 drive enable
  output logic                  O_CORE_RESET_N,       // core reset, active low
  output logic                  O_SMBUS_ACTIVE,       // smbus engines enabled
  output logic                  O_HALTED,             // held in reset
  output logic      [2:0]       O_PORT_CLOCKING,      // port clocking mode
  output logic      [7:0]       O_REFCLK_MHZ,         // refclk frequency
  output logic                  O_SMBUS_SLOW,         // host smbus slow
  output logic      [8:0]       O_SMBUS_KHZ,          // host smbus rate
  output logic      [PAIRS-1:0] O_PAIR_MERGED,        // pair runs as one x8
  output bsmc_part_type         O_PART_KIND,          // partition kind
  output logic                  O_EEPROM_INIT,        // eeprom init wanted
  output logic                  O_UPSTREAM_P2,        // port 2 upstream
  output logic                  O_PORT0_DISABLE,      // port 0 disabled
  output logic                  O_PORT2_DISABLE,      // port 2 disabled
  input  wire logic             I_PSEL,               // apb select
  input  wire logic             I_PENABLE,            // apb enable
  input  wire logic             I_PWRITE,             // apb write
  input  wire logic [7:0]       I_PADDR,              // apb byte address
  input  wire logic [31:0]      I_PWDATA,             // apb write data
  output logic      [31:0]      O_PRDATA,             // apb read data
  output logic                  O_PREADY,             // apb ready
  output logic                  O_PSLVERR             // apb error
);

  localparam int SW    = 3 + 1 + 1 + PAIRS + 4 + 1;
  localparam int CNT_W = $clog2(RST_PROC_CYC + 1);

  generate
    if (RST_PROC_CYC < 1 || PAIRS < 1 || SW > 32)
    begin : g_chk
      $error("bsmc_top: parameters out of range");
    end
  endgenerate

  //--------------------------------------------------------------------
  // strap capture
  //--------------------------------------------------------------------
  logic [SW-1:0] strap_q;
  logic          strap_valid;
  logic [2:0]    s_clk;
  logic          s_freq;
  logic          s_slow;
  logic [PAIRS-1:0] s_pair;
  logic [3:0]    s_mode;
  logic          s_halt;

  // partition mode straps are assumed static after release
  bsmc_strap_latch #(.W(SW)) u_latch (
    .i_clk     (I_CLK_SYS),
    .i_arst_n  (I_ARST_N),
    .i_raw     ({I_HOLD_IN_RESET, I_PARTITION_MODE, I_PAIR_COMBINE_N,
                 I_SLOW_SMBUS_STRAP, I_REFCLK_FREQ_SEL, I_PORT_CLOCKING_SEL}),
    .o_val_q   (strap_q),
    .o_valid_q (strap_valid)
  );

  assign {s_halt, s_mode, s_pair, s_slow, s_freq, s_clk} = strap_q;

  bsmc_mode_decode #(.PAIRS(PAIRS)) u_decode (
    .i_clk       (I_CLK_SYS),
    .i_arst_n    (I_ARST_N),
    .i_valid     (strap_valid),
    .i_mode      (s_mode),
    .i_combine_n (s_pair),
    .o_merged_q  (O_PAIR_MERGED),
    .o_kind_q    (O_PART_KIND),
    .o_eeprom_q  (O_EEPROM_INIT),
    .o_up_p2_q   (O_UPSTREAM_P2),
    .o_p0_dis_q  (O_PORT0_DISABLE),
    .o_p2_dis_q  (O_PORT2_DISABLE)
  );

  //--------------------------------------------------------------------
  // clock and smbus settings
  //--------------------------------------------------------------------
  logic [2:0] clk_d;
  logic [7:0] mhz_d;
  logic       slow_d;
  logic [8:0] khz_d;

  // no register path reaches the smbus rate, so software cannot override it
  always_comb
  begin
    clk_d  = strap_valid ? s_clk : 3'h0;
    mhz_d  = s_freq ? `BSMC_REFCLK_HI_MHZ : `BSMC_REFCLK_LO_MHZ;
    slow_d = strap_valid & s_slow;
    khz_d  = slow_d ? `BSMC_SMB_SLOW_KHZ : `BSMC_SMB_FAST_KHZ;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_PORT_CLOCKING <= 3'h0;
      O_REFCLK_MHZ    <= `BSMC_REFCLK_LO_MHZ;
      O_SMBUS_SLOW    <= 1'b0;
      O_SMBUS_KHZ     <= `BSMC_SMB_FAST_KHZ;
    end
    else
    begin
      O_PORT_CLOCKING <= clk_d;
      O_REFCLK_MHZ    <= mhz_d;
      O_SMBUS_SLOW    <= slow_d;
      O_SMBUS_KHZ     <= khz_d;
    end
  end

  //--------------------------------------------------------------------
  // reset sequencer
  //--------------------------------------------------------------------
  bsmc_state_type   state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      BSMC_ST_CAPTURE:
      begin
        state_d = BSMC_ST_RESET_PROC;
        cnt_d   = '0;
      end
      BSMC_ST_RESET_PROC:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CNT_W'(RST_PROC_CYC - 1))
        begin
          state_d = s_halt ? BSMC_ST_HALTED : BSMC_ST_RUN;
        end
      end
      BSMC_ST_HALTED:
      begin
        if (I_HALT_CLEAR)
        begin
          state_d = BSMC_ST_RUN;
        end
      end
      BSMC_ST_RUN:
      begin
        state_d = BSMC_ST_RUN;
      end
      default:
      begin
        state_d = BSMC_ST_CAPTURE;
      end
    endcase
  end

  // everything above is cleared by the global reset
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      state_q        <= BSMC_ST_CAPTURE;
      cnt_q          <= '0;
      O_CORE_RESET_N <= 1'b0;
      O_SMBUS_ACTIVE <= 1'b0;
      O_HALTED       <= 1'b0;
    end
    else
    begin
      state_q        <= state_d;
      cnt_q          <= cnt_d;
      O_CORE_RESET_N <= (state_d == BSMC_ST_RUN);
      O_SMBUS_ACTIVE <= (state_d == BSMC_ST_HALTED) | (state_d == BSMC_ST_RUN);
      O_HALTED       <= (state_d == BSMC_ST_HALTED);
    end
  end

  //--------------------------------------------------------------------
  // gpio 50..53 and slot 4 outputs
  //--------------------------------------------------------------------
  logic [11:0] ctrl_q, ctrl_d;
  logic [3:0]  hp_out;
  logic [3:0]  alt;
  logic [3:0]  gout_d, goe_d;

  assign hp_out = {I_SLOT4_RESET_N, I_SLOT4_POWER_EN, I_SLOT4_POWER_LED, I_SLOT4_ATTN_LED};
  assign alt    = ctrl_q[`BSMC_CTRL_ALT_LSB +: 4];

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      gout_d[i] = alt[i] ? hp_out[i] : ctrl_q[`BSMC_CTRL_OUT_LSB + i];
      goe_d[i]  = alt[i] | ctrl_q[`BSMC_CTRL_DIR_LSB + i];
    end
  end

  //--------------------------------------------------------------------
  // apb slave, zero wait states
  //--------------------------------------------------------------------
  logic        setup, access, mapped;
  logic [31:0] rdata_d;

  assign setup  = I_PSEL & ~I_PENABLE;
  assign access = I_PSEL & I_PENABLE;
  assign mapped = (I_PADDR == `BSMC_OFS_GPIO_CTRL) | (I_PADDR == `BSMC_OFS_GPIO_IN) |
                  (I_PADDR == `BSMC_OFS_STRAPS) | (I_PADDR == `BSMC_OFS_STATE);
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = access & ~mapped;

  // read data is sampled in setup so it comes from a flop in access
  always_comb
  begin
    ctrl_d  = ctrl_q;
    rdata_d = O_PRDATA;
    if (access && I_PWRITE && I_PADDR == `BSMC_OFS_GPIO_CTRL)
    begin
      ctrl_d = I_PWDATA[11:0];
    end
    if (setup)
    begin
      case (I_PADDR)
        `BSMC_OFS_GPIO_CTRL: rdata_d = {20'h00000, ctrl_q};
        `BSMC_OFS_GPIO_IN:   rdata_d = {28'h0000000, I_GPIO_IN};
        `BSMC_OFS_STRAPS:    rdata_d = {{(32 - SW){1'b0}}, strap_q};
        `BSMC_OFS_STATE:     rdata_d = {28'h0000000, O_CORE_RESET_N, O_HALTED, state_q};
        default:             rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      ctrl_q     <= `BSMC_CTRL_RST;
      O_PRDATA   <= 32'h00000000;
      O_GPIO_OUT <= 4'h0;
      O_GPIO_OE  <= 4'h0;
    end
    else
    begin
      ctrl_q     <= ctrl_d;
      O_PRDATA   <= rdata_d;
      O_GPIO_OUT <= gout_d;
      O_GPIO_OE  <= goe_d;
    end
  end

  //--------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------
  default clocking dc @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_ARST_N);

  sequence halt_wait_s;
    (state_q == BSMC_ST_HALTED) && !I_HALT_CLEAR;
  endsequence

  sequence alt_sel_s;
    alt[3] && (ctrl_d == ctrl_q);
  endsequence

  halt_stays_a : assert property (
    halt_wait_s |=> state_q == BSMC_ST_HALTED && !O_CORE_RESET_N)
    else $error("left halt without a clear");

  run_cause_a : assert property (
    $rose(O_CORE_RESET_N) |-> ($past(state_q) == BSMC_ST_HALTED && $past(I_HALT_CLEAR)) ||
                               ($past(state_q) == BSMC_ST_RESET_PROC && !s_halt))
    else $error("core reset released without cause");

  halt_smbus_a : assert property (
    (state_q == BSMC_ST_HALTED) |-> O_SMBUS_ACTIVE && !O_CORE_RESET_N && O_HALTED)
    else $error("halted state without smbus");

  proc_len_a : assert property (
    (state_q == BSMC_ST_RESET_PROC) |->
      !O_SMBUS_ACTIVE && (!$rose(state_q == BSMC_ST_RESET_PROC) || cnt_q == '0) ##1
      ((state_q == BSMC_ST_RESET_PROC) == ($past(cnt_q) != CNT_W'(RST_PROC_CYC - 1))))
    else $error("reset procedure length wrong");

  reset_all_a : assert property (
    !strap_valid |-> !O_CORE_RESET_N && !O_SMBUS_ACTIVE && state_q == BSMC_ST_CAPTURE)
    else $error("state not cleared by reset");

  refclk_map_a : assert property (
    strap_valid |=> O_REFCLK_MHZ == ($past(s_freq) ? 8'h7D : 8'h64))
    else $error("refclk frequency wrong");

  smbus_rate_a : assert property (
    strap_valid |=> O_SMBUS_KHZ == ($past(s_slow) ? 9'h064 : 9'h190) && O_SMBUS_SLOW == $past(s_slow))
    else $error("smbus rate wrong");

  clk_mode_a : assert property (
    strap_valid |=> O_PORT_CLOCKING == $past(s_clk))
    else $error("clocking mode wrong");

  strap_hold_a : assert property (
    ($past(strap_valid) && strap_valid) |-> $stable(strap_q))
    else $error("captured straps changed");

  slot_reset_a : assert property (
    alt_sel_s |=> O_GPIO_OE[3] && O_GPIO_OUT[3] == $past(I_SLOT4_RESET_N))
    else $error("slot reset not on pin 53");

endmodule : bsmc_top

// >>> sim/bsmc_board.sv
// board model: strap resistors, reset source and smbus master
`timescale 1ns/1ps
module bsmc_board (
  input  wire logic  i_clk,        // system clock
  output logic       o_arst_n,     // global reset, active low
  output logic [15:0] o_straps,    // strap levels, laid out as the strap register
  output logic       o_halt_clear  // smbus master clears the halt bit
);
  initial
  begin
    o_arst_n     = 1'b0;
    o_straps     = 16'h0000;
    o_halt_clear = 1'b0;
  end

  // ----------------------------------------------------------------------
  // reset with new straps, then an early clear that must be ignored
  // ----------------------------------------------------------------------
  task automatic do_reset(input logic [15:0] s, input int cyc);
    @(posedge i_clk);
    o_arst_n <= 1'b0;
    o_straps <= s;
    repeat (cyc) @(posedge i_clk);
    o_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_halt_clear <= 1'b1;
    @(posedge i_clk);
    o_halt_clear <= 1'b0;
  endtask : do_reset

  // mode and hold bits stay fixed once reset is released; the others may move
  task automatic wiggle(input logic [15:0] v);
    @(posedge i_clk);
    o_straps <= {o_straps[15:11], v[10:0]};
  endtask : wiggle

  task automatic release_halt();
    @(posedge i_clk);
    o_halt_clear <= 1'b1;
    @(posedge i_clk);
    o_halt_clear <= 1'b0;
  endtask : release_halt
endmodule : bsmc_board

// >>> sim/boot_strap_mode_config_test.sv
// self-checking bench of the strap capture and reset halt block
`timescale 1ns/1ps
`include "bsmc_map.svh"
module boot_strap_mode_config_test
  import bsmc_pkg::*;
;
  logic clk, rst_n, hclr, psel, pen, pwr, pready, pslverr;
  logic core_n, smb, halted, sslow, ee, up2, d0, d2, core_p, halt_p, wr_p, wr_p2;
  logic [15:0] s;
  logic [15:0] straps;
  logic [7:0] paddr, mhz;
  logic [31:0] pwdata, prdata;
  logic [3:0] hp, gin, gout, goe, hpv, ginv, oe;
  logic [2:0] pclk;
  logic [8:0] khz;
  logic [5:0] merged;
  logic [11:0] c;
  bsmc_part_type kind;
  logic [63:0] cfg_q[$], rd_q[$], pin_q[$];
  logic [63:0] cfg_now;
  int errors, check_count, seed;

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  bsmc_board board (.i_clk(clk), .o_arst_n(rst_n), .o_straps(straps), .o_halt_clear(hclr));

  bsmc_top #(.RST_PROC_CYC(4), .PAIRS(6)) uut (
    .I_CLK_SYS(clk), .I_ARST_N(rst_n), .I_PORT_CLOCKING_SEL(straps[2:0]), .I_REFCLK_FREQ_SEL(straps[3]),
    .I_SLOW_SMBUS_STRAP(straps[4]), .I_PAIR_COMBINE_N(straps[10:5]), .I_PARTITION_MODE(straps[14:11]),
    .I_HOLD_IN_RESET(straps[15]), .I_HALT_CLEAR(hclr), .I_SLOT4_ATTN_LED(hp[0]), .I_SLOT4_POWER_LED(hp[1]),
    .I_SLOT4_POWER_EN(hp[2]), .I_SLOT4_RESET_N(hp[3]), .I_GPIO_IN(gin), .O_GPIO_OUT(gout), .O_GPIO_OE(goe),
    .O_CORE_RESET_N(core_n), .O_SMBUS_ACTIVE(smb), .O_HALTED(halted), .O_PORT_CLOCKING(pclk),
    .O_REFCLK_MHZ(mhz), .O_SMBUS_SLOW(sslow), .O_SMBUS_KHZ(khz), .O_PAIR_MERGED(merged), .O_PART_KIND(kind),
    .O_EEPROM_INIT(ee), .O_UPSTREAM_P2(up2), .O_PORT0_DISABLE(d0), .O_PORT2_DISABLE(d2), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr));

  assign cfg_now = 64'({pclk, mhz, khz, sslow, merged, kind, ee, up2, d0, d2, halted, smb, core_n});

  // ----------------------------------------------------------------------
  // expectations and comparison
  // ----------------------------------------------------------------------
  function automatic logic [63:0] exp_cfg(input logic [15:0] v, input logic run);
    logic [3:0] m;
    bsmc_part_type k;
    logic [3:0] f;
    m = v[14:11];
    k = BSMC_PM_RESERVED;
    f = 4'h0;
    if (m <= 4'h1) begin k = BSMC_PM_SINGLE; f = {m[0], 3'h0}; end
    else if (m >= 4'h8 && m <= 4'hB) begin k = BSMC_PM_SINGLE_FIXED_UP; f = {m[1], m[0], m[0], !m[0]}; end
    else if (m == 4'hC || m == 4'hD) begin k = BSMC_PM_MULTI; f = {m[0], 3'h0}; end
    return 64'({v[2:0], v[3] ? `BSMC_REFCLK_HI_MHZ : `BSMC_REFCLK_LO_MHZ,
                v[4] ? `BSMC_SMB_SLOW_KHZ : `BSMC_SMB_FAST_KHZ, v[4], ~v[10:5], k, f, !run, 1'b1, run});
  endfunction : exp_cfg

  task automatic take(input logic [63:0] got, ref logic [63:0] q[$]);
    logic [63:0] e;
    e = (q.size() > 0) ? q.pop_front() : {64{1'bx}};
    check_count++;
    if (got !== e)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, e);
    end
  endtask : take

  // results are taken off the queues as they appear at the outputs
  always @(posedge clk)
  begin
    core_p <= core_n;
    halt_p <= halted;
    wr_p   <= psel && pen && pready && pwr;
    wr_p2  <= wr_p;
    if ((core_n === 1'b1 && core_p !== 1'b1) || (halted === 1'b1 && halt_p !== 1'b1))
      take(cfg_now, cfg_q);
    if (psel && pen && pready === 1'b1 && !pwr)
      take(64'({pslverr, prdata}), rd_q);
    if (wr_p2)
      take(64'({goe, gout & goe}), pin_q);
  end

  // ----------------------------------------------------------------------
  // apb master and waits
  // ----------------------------------------------------------------------
  // only the watchdog ends a wait for ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(64'(e));
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic wait_out(input logic want_halt);
    int n;
    n = 0;
    while ((want_halt ? halted : core_n) !== 1'b1 && n < 100) begin @(posedge clk); n++; end
    if (n == 100) begin errors++; $display("ERROR %0t: no completion", $time); end
  endtask : wait_out

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("ERROR %0t: timeout", $time);
    finish_test();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    psel   = 1'b0;
    pen    = 1'b0;
    pwr    = 1'b0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    hp     = 4'h0;
    gin    = 4'h0;
    errors = 0;
    check_count = 0;
    seed = $urandom(47);
    // every partition code, halting on the odd ones, each behind a fresh reset
    for (int m = 0; m < 16; m++)
    begin
      s = 16'($urandom);
      s[14:11] = 4'(m);
      s[15] = s[11];
      cfg_q.push_back(exp_cfg(s, !s[15]));
      board.do_reset(s, (m == 0) ? 20 : 3);
      wait_out(s[15]);
      rd(`BSMC_OFS_STRAPS, {17'h0, s});
      if (s[15])
      begin
        rd(`BSMC_OFS_STATE, 33'h6);
        cfg_q.push_back(exp_cfg(s, 1'b1));
        board.release_halt();
        wait_out(1'b0);
      end
      rd(`BSMC_OFS_STATE, 33'hB);
    end
    board.wiggle(16'($urandom));
    rd(`BSMC_OFS_STRAPS, {17'h0, s});
    hpv  = 4'($urandom);
    ginv = 4'($urandom);
    @(posedge clk);
    hp  <= hpv;
    gin <= ginv;
    for (int i = 0; i < 4; i++)
    begin
      c = 12'($urandom);
      if (i == 0) c[3:0] = 4'hF;
      if (i == 1) c[3:0] = 4'h0;
      oe = c[3:0] | c[11:8];
      pin_q.push_back(64'({oe, ((c[3:0] & hpv) | (~c[3:0] & c[7:4])) & oe}));
      apb(1'b1, `BSMC_OFS_GPIO_CTRL, {20'h0, c});
      rd(`BSMC_OFS_GPIO_CTRL, {21'h0, c});
    end
    rd(`BSMC_OFS_GPIO_IN, {29'h0, ginv});
    rd(8'h10, {1'b1, 32'h0});
    repeat (3) @(posedge clk);
    if (cfg_q.size() + rd_q.size() + pin_q.size() != 0)
    begin
      errors++;
      $display("ERROR %0t: results missing", $time);
    end
    finish_test();
  end
endmodule : boot_strap_mode_config_test
